// >>> dv/rasr_top_tb_top.sv
// testbench: randomised register traffic and decoded-output checks for the A-setting bank
`timescale 1ns/100ps
module rasr_top_tb_top;
  import rasr_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic             sys_clk;
  logic             reset;
  logic             avs_read;
  logic             avs_write;
  logic [7:0]       avs_address;
  logic [31:0]      avs_writedata;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             set_b;
  logic             b_sleep;
  rasr_setting_type  io_a;
  rasr_setting_type  peri_a;
  rasr_setting_type  l3_a;
  rasr_setting6_type l7_a;
  logic             peri_sleep;
  logic             peri_auto;
  int               n_errors = 0;
  int               checks = 0;
  logic [7:0]       lfsr = 8'h5D;
  logic [7:0]       mem [10];
  logic [7:0]       addrs [10] = '{PERI_BUCK_CONF_OFFS, IO_BUCK_A_OFFS, PERI_BUCK_A_OFFS,
                                   8'hA9, 8'hAA, LINREG3_A_OFFS, 8'hAC, 8'hAD, 8'hAE,
                                   LINREG7_A_OFFS};
  // linreg seven corners: below, at and above the clamp, and the stored bit 6
  logic [7:0]       l7c [4] = '{8'h37, 8'hB8, 8'h3F, 8'hFF};
  logic [31:0]      rdat;
  logic [7:0]       d;

  rasr_top rasr_top_inst (
    .SYS_CLK_IN                 (sys_clk),
    .RESET_IN                   (reset),
    .AVS_READ_IN                (avs_read),
    .AVS_WRITE_IN               (avs_write),
    .AVS_ADDRESS_IN             (avs_address),
    .AVS_WRITEDATA_IN           (avs_writedata),
    .AVS_READDATA_OUT           (avs_readdata),
    .AVS_WAITREQUEST_OUT        (avs_waitrequest),
    .SET_B_SELECT_IN            (set_b),
    .PERIPH_BUCK_SLEEP_SEL_B_IN (b_sleep),
    .IO_BUCK_A_OUT              (io_a),
    .PERIPH_BUCK_A_OUT          (peri_a),
    .LINREG3_A_OUT              (l3_a),
    .LINREG7_A_OUT              (l7_a),
    .PERIPH_BUCK_SLEEP_OUT      (peri_sleep),
    .PERIPH_BUCK_AUTO_OUT       (peri_auto)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  function automatic logic [6:0] exp_l7(input logic [7:0] v);
    return {v[7], (v[5:0] >= LINREG7_SAT_CODE) ? LINREG7_SAT_CODE : v[5:0]};
  endfunction

  function automatic logic exp_sleep(input logic [7:0] conf, input logic [7:0] a,
                                     input logic sel, input logic b);
    case (conf[7:6])
      PERI_MODE_FOLLOW: return sel ? b : a[7];
      PERI_MODE_SLEEP:  return 1'b1;
      default:          return 1'b0;
    endcase
  endfunction

  task automatic summarize();
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] rd_data);
    int n;
    @(posedge sys_clk);
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_address   <= a;
    avs_writedata <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
      summarize();
    end
    rd_data = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic check_outs();
    check("io_buck_a", {24'h000000, mem[1]}, {24'h000000, io_a});
    check("peri_buck_a", {24'h000000, mem[2]}, {24'h000000, peri_a});
    check("linreg3_a", {24'h000000, mem[5]}, {24'h000000, l3_a});
    check("linreg7_a", {25'h0, exp_l7(mem[9])}, {25'h0, l7_a});
    check("peri_sleep", {31'h0, exp_sleep(mem[0], mem[2], set_b, b_sleep)},
          {31'h0, peri_sleep});
    check("peri_auto", {31'h0, mem[0][7:6] == PERI_MODE_AUTO}, {31'h0, peri_auto});
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    set_b = 1'b0;
    b_sleep = 1'b0;
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        mem[i] = SETTING_RESET;
        bus(1'b1, addrs[i], 8'h00, rdat);
        check("reset_value", 32'h00000000, rdat);
      end
      @(negedge sys_clk);
      check_outs();
      for (int r = 0; r < 12 && p == 0; r++) begin
        for (int i = 0; i < 10; i++) begin
          d = rnd();
          if (r < 4 && i == 0) d[7:6] = r[1:0];
          if (r < 4 && i == 9) d = l7c[r];
          mem[i] = d;
          bus(1'b0, addrs[i], d, rdat);
        end
        bus(1'b0, 8'hB0, rnd(), rdat);
        bus(1'b1, 8'hB0, 8'h00, rdat);
        check("unmapped_read", UNMAPPED_DATA, rdat);
        d = rnd();
        set_b   <= d[0];
        b_sleep <= d[1];
        for (int i = 0; i < 10; i++) begin
          bus(1'b1, addrs[i], 8'h00, rdat);
          check("read_back", {24'h000000, mem[i]}, rdat);
        end
        @(negedge sys_clk);
        check_outs();
      end
    end
    summarize();
  end
endmodule

// >>> verilog/rasr_byte_reg.sv
// one 8-bit storage register with write enable and synchronous reset
`timescale 1ns/100ps
module rasr_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // write side
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_data_in,
  // stored value
  output logic      [7:0] q_out
);
  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (wr_en_in) begin
      nxt_q = wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;
endmodule

// >>> verilog/rasr_pkg.sv
// package: register map, field layout and bus types for the regulator A-setting bank
package rasr_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses of 8-bit registers)
  // ------------------------------------------------------------
  localparam logic [7:0] IO_BUCK_A_OFFS    = 8'hA7;
  localparam logic [7:0] PERI_BUCK_A_OFFS  = 8'hA8;
  localparam logic [7:0] RSVD_ONE_LO_OFFS  = 8'hA9;
  localparam logic [7:0] RSVD_ONE_HI_OFFS  = 8'hAA;
  localparam logic [7:0] LINREG3_A_OFFS    = 8'hAB;
  localparam logic [7:0] RSVD_TWO_LO_OFFS  = 8'hAC;
  localparam logic [7:0] RSVD_TWO_HI_OFFS  = 8'hAE;
  localparam logic [7:0] LINREG7_A_OFFS    = 8'hAF;
  localparam logic [7:0] PERI_BUCK_CONF_OFFS = 8'hA2;

  // ------------------------------------------------------------
  // bank layout: index = offset - base
  // ------------------------------------------------------------
  localparam logic [7:0] BANK_BASE  = 8'hA7;
  localparam int         BANK_DEPTH = 9;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SLEEP_SEL_BIT  = 7;
  localparam int CODE7_MSB      = 6;
  localparam int CODE6_MSB      = 5;
  localparam int PERI_MODE_MSB  = 7;
  localparam int PERI_MODE_LSB  = 6;

  // ------------------------------------------------------------
  // reset values and constants
  // ------------------------------------------------------------
  localparam logic [7:0] SETTING_RESET   = 8'h00;
  localparam logic [1:0] PERI_MODE_RESET = 2'h0;
  localparam logic [1:0] PERI_MODE_FOLLOW = 2'h0;
  localparam logic [1:0] PERI_MODE_SLEEP  = 2'h1;
  localparam logic [1:0] PERI_MODE_SYNC   = 2'h2;
  localparam logic [1:0] PERI_MODE_AUTO   = 2'h3;
  localparam logic [5:0] LINREG7_SAT_CODE = 6'h38;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } rasr_req_type;

  typedef struct packed {
    logic       sleep_sel;
    logic [6:0] volt_code;
  } rasr_setting_type;

  typedef struct packed {
    logic       sleep_sel;
    logic [5:0] volt_code;
  } rasr_setting6_type;

endpackage

// >>> verilog/rasr_top.sv
// top: Avalon-MM register bank holding the regulator A settings and decoded controls
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps

// How it works
// - io buck: bit7 sleep/sync, bits6:0 code
// - peripheral buck: bit7 sleep/sync, bits6:0 code
// - linear regulators: bit7 half-current or sleep
// - linreg three: 7-bit code, 20 mV steps
// - linreg seven: 6-bit code, saturates at 111000
// - peripheral mode 00 follows selected set bit
module rasr_top
  import rasr_pkg::*;
(
  // clock and reset
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        RESET_IN,
  // avalon-mm slave
  input  wire logic                        AVS_READ_IN,
  input  wire logic                        AVS_WRITE_IN,
  input  wire logic [7:0]                  AVS_ADDRESS_IN,
  input  wire logic [31:0]                 AVS_WRITEDATA_IN,
  output logic      [31:0]                 AVS_READDATA_OUT,
  output logic                             AVS_WAITREQUEST_OUT,
  // voltage-set selection and B-set mode bit for the peripheral buck
  input  wire logic                        SET_B_SELECT_IN,
  input  wire logic                        PERIPH_BUCK_SLEEP_SEL_B_IN,
  // regulator controls
  output rasr_pkg::rasr_setting_type       IO_BUCK_A_OUT,
  output rasr_pkg::rasr_setting_type       PERIPH_BUCK_A_OUT,
  output rasr_pkg::rasr_setting_type       LINREG3_A_OUT,
  output rasr_pkg::rasr_setting6_type      LINREG7_A_OUT,
  output logic                             PERIPH_BUCK_SLEEP_OUT,
  output logic                             PERIPH_BUCK_AUTO_OUT
);
  import rasr_pkg::*;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  rasr_req_type req;
  logic         ack_ff;
  logic         nxt_ack;
  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;

  assign req = '{read: AVS_READ_IN, write: AVS_WRITE_IN,
                 address: AVS_ADDRESS_IN, writedata: AVS_WRITEDATA_IN};

  // one wait cycle: request seen, answered at the following edge
  always_comb begin
    nxt_ack = 1'b0;
    if ((req.read || req.write) && !ack_ff) begin
      nxt_ack = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // storage: bank indices 0..8 = offsets A7..AF, plus mode config
  // ------------------------------------------------------------
  logic [7:0] bank_q [BANK_DEPTH];
  logic [7:0] idx;
  logic       in_bank;
  logic       wr_go;
  logic [7:0] conf_ff;
  logic [7:0] nxt_conf;

  assign idx     = req.address - BANK_BASE;
  assign in_bank = (req.address >= BANK_BASE) && (req.address <= LINREG7_A_OFFS);
  assign wr_go   = req.write && nxt_ack;

  genvar g;
  generate
    for (g = 0; g < BANK_DEPTH; g++) begin : g_bank
      // reserved addresses have their own storage so they never touch settings
      rasr_byte_reg #(.RESET_VAL(SETTING_RESET)) u_reg (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (RESET_IN),
        .wr_en_in   (wr_go && in_bank && (idx == 8'(g))),
        .wr_data_in (req.writedata[7:0]),
        .q_out      (bank_q[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_conf = conf_ff;
    if (wr_go && (req.address == PERI_BUCK_CONF_OFFS)) begin
      nxt_conf = req.writedata[7:0];
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req.read && nxt_ack) begin
      if (in_bank) begin
        nxt_rdata = {24'h000000, bank_q[idx[3:0]]};
      end else if (req.address == PERI_BUCK_CONF_OFFS) begin
        nxt_rdata = {24'h000000, conf_ff};
      end else begin
        nxt_rdata = UNMAPPED_DATA;
      end
    end
  end

  // ------------------------------------------------------------
  // decoded regulator controls
  // ------------------------------------------------------------
  localparam int IO_IDX  = 0;
  localparam int PB_IDX  = 1;
  localparam int L3_IDX  = 4;
  localparam int L7_IDX  = 8;

  rasr_setting_type  nxt_io;
  rasr_setting_type  nxt_pb;
  rasr_setting_type  nxt_l3;
  rasr_setting6_type nxt_l7;
  logic [1:0]        pb_mode;
  logic              nxt_pb_sleep;
  logic              nxt_pb_auto;

  always_comb begin
    nxt_io.sleep_sel = bank_q[IO_IDX][SLEEP_SEL_BIT];
    nxt_io.volt_code = bank_q[IO_IDX][CODE7_MSB:0];
    nxt_pb.sleep_sel = bank_q[PB_IDX][SLEEP_SEL_BIT];
    nxt_pb.volt_code = bank_q[PB_IDX][CODE7_MSB:0];
    nxt_l3.sleep_sel = bank_q[L3_IDX][SLEEP_SEL_BIT];
    nxt_l3.volt_code = bank_q[L3_IDX][CODE7_MSB:0];
    nxt_l7.sleep_sel = bank_q[L7_IDX][SLEEP_SEL_BIT];
    // codes above the saturation point drive the top voltage
    if (bank_q[L7_IDX][CODE6_MSB:0] >= LINREG7_SAT_CODE) begin
      nxt_l7.volt_code = LINREG7_SAT_CODE;
    end else begin
      nxt_l7.volt_code = bank_q[L7_IDX][CODE6_MSB:0];
    end
    pb_mode = conf_ff[PERI_MODE_MSB:PERI_MODE_LSB];
    nxt_pb_auto = (pb_mode == PERI_MODE_AUTO);
    unique case (pb_mode)
      PERI_MODE_FOLLOW: begin
        nxt_pb_sleep = SET_B_SELECT_IN ? PERIPH_BUCK_SLEEP_SEL_B_IN
                                       : nxt_pb.sleep_sel;
      end
      PERI_MODE_SLEEP: begin
        nxt_pb_sleep = 1'b1;
      end
      PERI_MODE_SYNC: begin
        nxt_pb_sleep = 1'b0;
      end
      PERI_MODE_AUTO: begin
        nxt_pb_sleep = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ack_ff                <= 1'b0;
      rdata_ff              <= UNMAPPED_DATA;
      conf_ff               <= {PERI_MODE_RESET, 6'h00};
      IO_BUCK_A_OUT         <= '0;
      PERIPH_BUCK_A_OUT     <= '0;
      LINREG3_A_OUT         <= '0;
      LINREG7_A_OUT         <= '0;
      PERIPH_BUCK_SLEEP_OUT <= 1'b0;
      PERIPH_BUCK_AUTO_OUT  <= 1'b0;
      AVS_WAITREQUEST_OUT   <= 1'b1;
    end else begin
      ack_ff                <= nxt_ack;
      rdata_ff              <= nxt_rdata;
      conf_ff               <= nxt_conf;
      IO_BUCK_A_OUT         <= nxt_io;
      PERIPH_BUCK_A_OUT     <= nxt_pb;
      LINREG3_A_OUT         <= nxt_l3;
      LINREG7_A_OUT         <= nxt_l7;
      PERIPH_BUCK_SLEEP_OUT <= nxt_pb_sleep;
      PERIPH_BUCK_AUTO_OUT  <= nxt_pb_auto;
      AVS_WAITREQUEST_OUT   <= !nxt_ack;
    end
  end

  assign AVS_READDATA_OUT = rdata_ff;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_io_field_map: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == IO_BUCK_A_OFFS
    |=> IO_BUCK_A_OUT == $past(req.writedata[7:0], 2))
    else $error("io buck output does not follow written value");

  a_peri_field_map: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == PERI_BUCK_A_OFFS
    |=> PERIPH_BUCK_A_OUT == $past(req.writedata[7:0], 2))
    else $error("peripheral buck output does not follow written value");

  a_l3_sleep_bit: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    ##1 LINREG3_A_OUT.sleep_sel == $past(bank_q[L3_IDX][SLEEP_SEL_BIT]))
    else $error("linreg3 sleep bit mismatch");

  a_l3_code_map: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == LINREG3_A_OFFS
    |=> LINREG3_A_OUT == $past(req.writedata[7:0], 2))
    else $error("linreg3 output does not follow written value");

  a_l7_saturate: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    LINREG7_A_OUT.volt_code <= LINREG7_SAT_CODE)
    else $error("linreg7 code above saturation");

  a_peri_follow: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (pb_mode == PERI_MODE_FOLLOW && !SET_B_SELECT_IN)
    |=> PERIPH_BUCK_SLEEP_OUT == $past(bank_q[PB_IDX][SLEEP_SEL_BIT]))
    else $error("peripheral buck sleep not following A set");

  a_readback: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (req.read && nxt_ack && in_bank)
    |=> AVS_READDATA_OUT[7:0] == $past(bank_q[idx[3:0]]) && !AVS_WAITREQUEST_OUT)
    else $error("read back differs from stored value");

  a_rsvd_isolate: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (wr_go && req.address != IO_BUCK_A_OFFS)
    |=> bank_q[IO_IDX] == $past(bank_q[IO_IDX]))
    else $error("write elsewhere changed io buck setting");

  a_wait_bound: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (req.read || req.write) && AVS_WAITREQUEST_OUT |-> ##[1:2] !AVS_WAITREQUEST_OUT)
    else $error("request not answered in two cycles");

  a_peri_follow_b: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (pb_mode == PERI_MODE_FOLLOW && SET_B_SELECT_IN)
    |=> PERIPH_BUCK_SLEEP_OUT == $past(PERIPH_BUCK_SLEEP_SEL_B_IN))
    else $error("peripheral buck sleep not following B set");

  a_l7_sleep_bit: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == LINREG7_A_OFFS
    |=> LINREG7_A_OUT.sleep_sel == $past(req.writedata[SLEEP_SEL_BIT], 2))
    else $error("linreg7 sleep bit does not follow written value");

  a_l7_pass_low: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == LINREG7_A_OFFS
    && $past(req.writedata[CODE6_MSB:0]) < LINREG7_SAT_CODE
    |=> LINREG7_A_OUT.volt_code == $past(req.writedata[CODE6_MSB:0], 2))
    else $error("linreg7 code below clamp not passed through");

  a_l7_clamp_high: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(wr_go) && $past(req.address) == LINREG7_A_OFFS
    && $past(req.writedata[CODE6_MSB:0]) >= LINREG7_SAT_CODE
    |=> LINREG7_A_OUT.volt_code == LINREG7_SAT_CODE)
    else $error("linreg7 code at or above clamp not saturated");

  a_peri_mode_sleep: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (pb_mode == PERI_MODE_SLEEP)
    |=> PERIPH_BUCK_SLEEP_OUT)
    else $error("peripheral buck forced sleep not applied");

  a_peri_mode_sync: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (pb_mode == PERI_MODE_SYNC) || (pb_mode == PERI_MODE_AUTO)
    |=> !PERIPH_BUCK_SLEEP_OUT)
    else $error("peripheral buck sleep set in sync or auto mode");

  a_peri_auto_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    ##1 PERIPH_BUCK_AUTO_OUT == $past(pb_mode == PERI_MODE_AUTO))
    else $error("peripheral buck auto flag mismatch");

  a_unmapped_zero: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (req.read && nxt_ack && !in_bank && req.address != PERI_BUCK_CONF_OFFS)
    |=> AVS_READDATA_OUT == UNMAPPED_DATA)
    else $error("unmapped read returned nonzero data");

  a_rdata_hold: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    !(req.read && nxt_ack)
    |=> $stable(AVS_READDATA_OUT))
    else $error("read data changed without a read");

  a_wait_one_cycle: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    !AVS_WAITREQUEST_OUT
    |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low for more than one cycle");

  a_ack_one_shot: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    ack_ff
    |-> !nxt_ack)
    else $error("request acknowledged twice in a row");

  a_wait_after_reset: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN)
    |-> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low right after reset");

  a_outs_after_reset: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    $past(RESET_IN)
    |-> IO_BUCK_A_OUT == 8'h00 && PERIPH_BUCK_A_OUT == 8'h00
        && LINREG3_A_OUT == 8'h00 && LINREG7_A_OUT == 7'h00)
    else $error("regulator outputs not cleared by reset");

  a_rsvd_keep_pb: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (wr_go && req.address != PERI_BUCK_A_OFFS)
    |=> bank_q[PB_IDX] == $past(bank_q[PB_IDX]))
    else $error("write elsewhere changed peripheral buck setting");

  a_rsvd_keep_l3: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (wr_go && req.address != LINREG3_A_OFFS)
    |=> bank_q[L3_IDX] == $past(bank_q[L3_IDX]))
    else $error("write elsewhere changed linreg3 setting");

  a_rsvd_keep_l7: assert property (@(posedge SYS_CLK_IN) disable iff (RESET_IN)
    (wr_go && req.address != LINREG7_A_OFFS)
    |=> bank_q[L7_IDX] == $past(bank_q[L7_IDX]))
    else $error("write elsewhere changed linreg7 setting");

endmodule
